/* File: src/ecsp_core.sv */
// Stream port of the codec with a one-entry output stage
`timescale 1ns/10ps
module ecsp_core (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Upstream side
    input wire logic in_valid,
    input wire ecsp_pkg::ecsp_in_s in_sym,
    output logic in_ready,
    // Downstream side
    output logic out_valid,
    output ecsp_pkg::ecsp_out_s out_sym,
    output logic [ecsp_pkg::DATA_W+ecsp_pkg::CNT_W-1:0] out_bus,
    input wire logic out_ready
);
    ecsp_pkg::ecsp_state_s st;
    ecsp_pkg::ecsp_state_s next_st;
    logic take;
    logic give;
    logic [ecsp_pkg::CNT_W-1:0] cnt_now;

    function automatic logic [ecsp_pkg::CNT_W-1:0] bump(input logic [ecsp_pkg::CNT_W-1:0] c);
        if (c == '1) begin
            return c;
        end
        return c + ecsp_pkg::CNT_ONE;
    endfunction

    // Stage is free or drains this cycle
    assign in_ready = clk_en && (!st.full || out_ready);
    assign take = in_valid && in_ready;
    assign give = clk_en && st.full && out_ready;
    assign out_valid = st.full;
    assign out_sym = st.hold;
    assign out_bus = {st.hold.data, st.hold.error_count};

    always_comb begin
        next_st = st;
        cnt_now = in_sym.sop ? ecsp_pkg::CNT_ZERO : st.run_count;
        if (in_sym.err) begin
            cnt_now = bump(cnt_now);
        end
        if (give) begin
            next_st.full = 1'b0;
        end
        if (take) begin
            next_st.full = 1'b1;
            next_st.hold.data = in_sym.data;
            next_st.hold.sop = in_sym.sop;
            next_st.hold.eop = in_sym.eop;
            next_st.hold.error_count = in_sym.eop ? cnt_now : ecsp_pkg::CNT_ZERO;
            next_st.hold.uncorr = in_sym.eop && (cnt_now > ecsp_pkg::CORR_MAX);
            next_st.run_count = in_sym.eop ? ecsp_pkg::CNT_ZERO : cnt_now;
            next_st.in_pkt = !in_sym.eop;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Checks
    sequence stalled_s;
        out_valid && !out_ready;
    endsequence

    hold_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
        (stalled_s and clk_en) |=> (out_valid && $stable(out_sym)))
        else $error("output changed while stalled");
    ready_rule_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !out_valid) |-> in_ready)
        else $error("ready low with empty stage");
    capture_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && in_valid && in_ready) |=> (out_valid && out_sym.data == $past(in_sym.data)))
        else $error("accepted symbol not presented");
    no_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !in_valid && (!out_valid || out_ready)) |=> !out_valid)
        else $error("valid without a capture");
    sop_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && in_valid && in_ready) |=> (out_sym.sop == $past(in_sym.sop)))
        else $error("start marker mismatch");
    eop_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && in_valid && in_ready) |=> (out_sym.eop == $past(in_sym.eop)))
        else $error("end marker mismatch");
    count_eop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (out_valid && !out_sym.eop) |-> (out_sym.error_count == ecsp_pkg::CNT_ZERO))
        else $error("count shown off end marker");
    uncorr_a: assert property (@(posedge clk) disable iff (!rst_n)
        out_valid |-> (out_sym.uncorr == (out_sym.eop &&
        out_sym.error_count > ecsp_pkg::CORR_MAX)))
        else $error("uncorrectable flag wrong");
    bus_join_a: assert property (@(posedge clk) disable iff (!rst_n)
        out_bus[ecsp_pkg::CNT_W-1:0] == out_sym.error_count)
        else $error("bus count field wrong");

    // Transfer shapes
    sequence take_s;
        clk_en && in_valid && in_ready;
    endsequence

    sequence give_s;
        clk_en && out_valid && out_ready;
    endsequence

    sequence refused_s;
        clk_en && in_valid && !in_ready;
    endsequence

    sequence frozen_s;
        !clk_en;
    endsequence

    sequence idle_in_s;
        clk_en && !in_valid;
    endsequence

    sequence head_s;
        clk_en && in_valid && in_ready && in_sym.sop;
    endsequence

    sequence tail_s;
        clk_en && in_valid && in_ready && in_sym.eop;
    endsequence

    sequence mid_s;
        clk_en && in_valid && in_ready && !in_sym.sop && !in_sym.eop;
    endsequence

    // Ready and freeze
    frz_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
        frozen_s
        |-> !in_ready)
        else $error("ready high while frozen");

    full_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && out_valid && !out_ready)
        |-> !in_ready)
        else $error("ready high with full stalled stage");

    drain_open_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && out_ready)
        |-> in_ready)
        else $error("ready low while stage drains");

    frz_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
        frozen_s
        |=> (out_valid == $past(out_valid)))
        else $error("valid moved while frozen");

    frz_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        frozen_s
        |=> $stable(out_sym))
        else $error("output moved while frozen");

    frz_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
        frozen_s
        |=> $stable(out_bus))
        else $error("bus moved while frozen");

    frz_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        frozen_s
        |=> $stable(st.run_count))
        else $error("count moved while frozen");

    // Refused and idle input, drain with take, stalled output
    refuse_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        refused_s
        |=> (out_valid && $stable(out_sym)))
        else $error("refused symbol changed output");

    refuse_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        refused_s
        |=> $stable(st.run_count))
        else $error("refused symbol changed count");

    idle_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        idle_in_s
        |=> $stable(st.run_count))
        else $error("idle input changed count");

    idle_empty_a: assert property (@(posedge clk) disable iff (!rst_n)
        (idle_in_s and give_s)
        |=> !out_valid)
        else $error("valid after drain with no input");

    give_take_a: assert property (@(posedge clk) disable iff (!rst_n)
        (give_s and take_s)
        |=> out_valid)
        else $error("stage empty after drain and take");

    stall_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && out_valid && !out_ready)
        |=> out_valid)
        else $error("valid dropped while stalled");

    // Output bus layout
    bus_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        out_valid
        |-> (out_bus[ecsp_pkg::DATA_W+ecsp_pkg::CNT_W-1:ecsp_pkg::CNT_W] == out_sym.data))
        else $error("bus data field wrong");

    bus_whole_a: assert property (@(posedge clk) disable iff (!rst_n)
        out_valid
        |-> (out_bus == {out_sym.data, out_sym.error_count}))
        else $error("bus layout wrong");

    // Error counting
    head_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        (head_s and !in_sym.eop)
        |=> (st.run_count == ($past(in_sym.err) ? ecsp_pkg::CNT_ONE : ecsp_pkg::CNT_ZERO)))
        else $error("count not restarted at start");

    tail_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        tail_s
        |=> (st.run_count == ecsp_pkg::CNT_ZERO))
        else $error("count not cleared at end");

    mid_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mid_s and in_sym.err && st.run_count != '1)
        |=> (st.run_count == $past(st.run_count) + ecsp_pkg::CNT_ONE))
        else $error("flagged symbol not counted");

    mid_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mid_s and !in_sym.err)
        |=> (st.run_count == $past(st.run_count)))
        else $error("clean symbol counted");

    mid_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mid_s and in_sym.err && st.run_count == '1)
        |=> (st.run_count == '1))
        else $error("count wrapped");

    single_cnt_a: assert property (@(posedge clk) disable iff (!rst_n)
        (head_s and tail_s)
        |=> (out_sym.error_count == ($past(in_sym.err) ? ecsp_pkg::CNT_ONE : ecsp_pkg::CNT_ZERO)))
        else $error("single symbol count wrong");

    tail_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tail_s and !in_sym.sop && !in_sym.err)
        |=> (out_sym.error_count == $past(st.run_count)))
        else $error("end count wrong");

    tail_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tail_s and !in_sym.sop && in_sym.err && st.run_count != '1)
        |=> (out_sym.error_count == $past(st.run_count) + ecsp_pkg::CNT_ONE))
        else $error("flagged end symbol not counted");

    mid_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (take_s and !in_sym.eop)
        |=> (out_sym.error_count == ecsp_pkg::CNT_ZERO))
        else $error("count shown before end");

    // Uncorrectable flag
    unc_mid_a: assert property (@(posedge clk) disable iff (!rst_n)
        (out_valid && !out_sym.eop)
        |-> !out_sym.uncorr)
        else $error("uncorrectable flag before end");

    unc_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (out_valid && out_sym.error_count <= ecsp_pkg::CORR_MAX)
        |-> !out_sym.uncorr)
        else $error("uncorrectable flag within capacity");

    unc_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        (out_valid && out_sym.eop && out_sym.error_count > ecsp_pkg::CORR_MAX)
        |-> out_sym.uncorr)
        else $error("uncorrectable flag missing");

    // Codeword markers
    track_a: assert property (@(posedge clk) disable iff (!rst_n)
        out_valid
        |-> (st.in_pkt == !out_sym.eop))
        else $error("codeword tracking wrong");

    sop_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        head_s
        |=> out_sym.sop)
        else $error("start marker missing");

    sop_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        (take_s and !in_sym.sop)
        |=> !out_sym.sop)
        else $error("start marker off first beat");

    eop_last_a: assert property (@(posedge clk) disable iff (!rst_n)
        tail_s
        |=> out_sym.eop)
        else $error("end marker missing");

    eop_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        (take_s and !in_sym.eop)
        |=> !out_sym.eop)
        else $error("end marker off last beat");

    pkt_open_a: assert property (@(posedge clk) disable iff (!rst_n)
        (head_s and !in_sym.eop)
        |=> st.in_pkt)
        else $error("codeword not opened");

    pkt_close_a: assert property (@(posedge clk) disable iff (!rst_n)
        tail_s
        |=> !st.in_pkt)
        else $error("codeword not closed");

    // Reset
    rst_empty_a: assert property (@(posedge clk)
        !rst_n
        |-> !out_valid)
        else $error("valid high in reset");

    rst_ready_a: assert property (@(posedge clk)
        (!rst_n && clk_en)
        |-> in_ready)
        else $error("ready low in reset");

    rst_count_a: assert property (@(posedge clk)
        !rst_n
        |-> (st.run_count == ecsp_pkg::CNT_ZERO))
        else $error("count not cleared in reset");
endmodule

/* File: src/ecsp_pkg.sv */
// Package with constants and carrier types for the codec stream port
package ecsp_pkg;
    localparam int DATA_W = 20;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CORR_MAX = 8'h28;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic sop;
        logic eop;
        logic err;
    } ecsp_in_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [CNT_W-1:0] error_count;
        logic sop;
        logic eop;
        logic uncorr;
    } ecsp_out_s;

    typedef struct packed {
        logic full;
        ecsp_out_s hold;
        logic [CNT_W-1:0] run_count;
        logic in_pkt;
    } ecsp_state_s;
endpackage

/* File: tb/ecsp_sink.sv */
// Downstream sink model that can stall
`timescale 1ns/10ps
module ecsp_sink (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control and ready
    input wire logic stall,
    output logic out_ready
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) out_ready <= 1'b0;
        else out_ready <= stall ? !out_ready : 1'b1;
    end
endmodule

/* File: tb/ecsp_test.sv */
// Testbench for the codec stream port
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t bad", $time); end end
module ecc_codec_stream_port_test;
    logic clk = 0, rst_n = 0, clk_en = 1, in_valid = 0, stall = 0;
    logic in_ready, out_valid, out_ready;
    ecsp_pkg::ecsp_in_s in_sym = '0;
    ecsp_pkg::ecsp_out_s out_sym;
    logic [ecsp_pkg::DATA_W+ecsp_pkg::CNT_W-1:0] out_bus;
    ecsp_pkg::ecsp_out_s exp[$];
    int bad_count = 0, checked = 0;
    ecsp_core uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .in_valid(in_valid),
        .in_sym(in_sym), .in_ready(in_ready), .out_valid(out_valid), .out_sym(out_sym),
        .out_bus(out_bus), .out_ready(out_ready));
    ecsp_sink sink (.clk(clk), .rst_n(rst_n), .stall(stall), .out_ready(out_ready));
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (clk_en && out_valid && out_ready) begin
        `CHK(exp.size() > 0, 1'b1)
        if (exp.size() > 0) begin
            `CHK(out_sym, exp[0])
            `CHK(out_bus, {exp[0].data, exp[0].error_count})
            void'(exp.pop_front());
        end
    end
    task automatic pkt(input int n, input int nerr, input logic st);
        ecsp_pkg::ecsp_out_s e;
        int w;
        stall = st;
        for (int i = 0; i < n; i++) begin
            in_sym = '{20'(i * 7 + n), i == 0, i == n - 1, i < nerr};
            in_valid = 1'b1;
            e = '{in_sym.data, (i == n - 1) ? 8'(nerr) : ecsp_pkg::CNT_ZERO, i == 0,
                i == n - 1, i == n - 1 && nerr > int'(ecsp_pkg::CORR_MAX)};
            exp.push_back(e);
            while (!in_ready) @(negedge clk);
            @(negedge clk);
        end
        in_valid = 1'b0;
        in_sym = '1;
        for (w = 0; w < 500 && exp.size() > 0; w++) @(negedge clk);
        `CHK(exp.size(), 0)
        $display("pkt %0d done", n);
    endtask
    task automatic freeze();
        clk_en = 1'b0;
        @(negedge clk);
        `CHK(in_ready, 1'b0)
        clk_en = 1'b1;
        $display("freeze done");
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        pkt(1, 1, 0);
        pkt(4, 2, 0);
        pkt(6, 3, 1);
        pkt(40, 40, 1);
        pkt(41, 41, 0);
        freeze();
        test_done();
    end
    initial begin
        #200us;
        bad_count++;
        test_done();
    end
endmodule
